// ### shared/pcrc_pkg.sv
// Package for the programmable serial CRC generator: offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one 50 MHz clock.
package pcrc_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_POLY = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
  localparam int CTL_LEN_LSB = 0;
  localparam int CTL_GO = 4;
  localparam int CTL_EMPTY = 6;
  localparam int CTL_FULL = 7;
  localparam int CTL_COUNT_LSB = 8;
  localparam int CTL_STOP_IDLE = 13;
  localparam logic [3:0] LEN_DEEP_MAX = 4'h7;
  localparam logic [4:0] DEPTH_SHALLOW = 5'h08;
  localparam logic [4:0] DEPTH_DEEP = 5'h10;
  localparam logic [15:0] POLY_RESET = 16'h0000;
  localparam logic [15:0] POLY_IMPL_MASK = 16'hfffe;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    PCRC_IDLE_ST = 1'b0,
    PCRC_SHIFT_ST = 1'b1
  } pcrc_state_e;
endpackage : pcrc_pkg

// ### shared/pcrc_shift_if.sv
// Interface between the register/FIFO front end and the serial CRC core.
// Assumes both ends on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface pcrc_shift_if;
  logic bit_valid;
  logic data_bit;
  logic [3:0] len;
  logic [15:0] poly;
  logic [15:0] crc;
  modport front (output bit_valid, output data_bit, output len, output poly, input crc);
  modport core (input bit_valid, input data_bit, input len, input poly, output crc);
endinterface : pcrc_shift_if
`default_nettype wire

// ### verif/pcrc_checker.sv
// Concurrent checks on the CRC generator's AXI4-Lite ports.
// Assumes bind into pcrc_top, one clock, active-high async reset.
`timescale 1ns/1ps
`default_nettype none
module pcrc_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  wire logic ar_ok = s_axi_arvalid && s_axi_arready;
  wire logic rd_ctl = ar_ok && s_axi_araddr == pcrc_pkg::ADDR_CONTROL;
  wire logic [4:0] cnt = s_axi_rdata[12:8];
  wire logic deep = s_axi_rdata[3:0] <= pcrc_pkg::LEN_DEEP_MAX;
  wire logic [4:0] dep = deep ? pcrc_pkg::DEPTH_DEEP : pcrc_pkg::DEPTH_SHALLOW;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  a_poly_bit_zero: assert property (ar_ok && s_axi_araddr == pcrc_pkg::ADDR_POLY
    |=> s_axi_rdata[0] == 1'b0 && s_axi_rdata[31:16] == 16'h0000) else $error("poly bit0 set");
  a_empty_flag: assert property (rd_ctl |=> s_axi_rdata[6] == (cnt == 5'h00))
    else $error("empty flag wrong");
  a_full_flag: assert property (rd_ctl |=> s_axi_rdata[7] == (cnt == dep))
    else $error("full flag wrong");
  a_count_limit: assert property (rd_ctl |=> cnt <= dep)
    else $error("count above depth");
  a_read_answer: assert property (ar_ok |=> s_axi_rvalid) else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_unmapped_err: assert property (ar_ok && s_axi_araddr > pcrc_pkg::ADDR_IRQ_MASK
    |=> s_axi_rresp == pcrc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("no slverr");
endmodule : pcrc_checker
bind pcrc_top pcrc_checker pcrc_checker_i (.clk_sys, .sys_rst, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ### verif/pcrc_top_tb.sv
// Self-checking bench for the CRC generator through its AXI4-Lite slave.
// Assumes pcrc_pkg, the interface and the design compiled first.
`timescale 1ns/1ps
`default_nettype none
module pcrc_top_tb;
  localparam logic [7:0] A_CTL = pcrc_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_POLY = pcrc_pkg::ADDR_POLY;
  localparam logic [7:0] A_DATA = pcrc_pkg::ADDR_DATA;
  localparam logic [7:0] A_ST = pcrc_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] A_MSK = pcrc_pkg::ADDR_IRQ_MASK;
  logic clk_sys = 0, sys_rst = 1, sleep_req = 0, idle_req = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int bad_count = 0, samples_checked = 0;
  pcrc_top pcrc_top_i (.clk_sys, .sys_rst, .sleep_req, .idle_req, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic pa, pw, pb;
    {pa, pw, pb} = 3'h7;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (pa || pw || pb) begin
      @(posedge clk_sys);
      if (s_axi_awready) pa = 0;
      if (s_axi_wready) pw = 0;
      if (s_axi_bvalid) begin
        pb = 0;
        chk("bresp", {32'h0, pcrc_pkg::RESP_OKAY}, {32'h0, s_axi_bresp});
      end
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {pa, pw, pb};
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, pb;
    {pa, pb} = 2'h3;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (pb) begin
      @(posedge clk_sys);
      if (s_axi_arready) pa = 0;
      if (s_axi_rvalid) begin
        pb = 0;
        d = s_axi_rdata;
        r = s_axi_rresp;
      end
      {s_axi_arvalid, s_axi_rready} <= {pa, pb};
    end
  endtask : rd
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(n, {(a > A_MSK) ? pcrc_pkg::RESP_SLVERR : pcrc_pkg::RESP_OKAY, e}, {r, d});
  endtask : rc
  task automatic ci(input logic e);
    @(posedge clk_sys);
    chk("irq", {33'h0, e}, {33'h0, irq});
  endtask : ci
  task automatic wait_empty;
    logic [31:0] d;
    logic [1:0] r;
    d = 0;
    while (d[6] !== 1'b1) rd(A_CTL, d, r);
  endtask : wait_empty
  // Serial model: MSb first, shift left, feedback from bit len
  function automatic logic [31:0] crc_of(input logic [31:0] s, input logic [15:0] d, input int l,
    input logic [15:0] p);
    logic [15:0] c;
    logic f;
    c = s[15:0];
    for (int i = l; i >= 0; i--) begin
      f = c[l] ^ d[i];
      c = c << 1;
      if (f) c = c ^ (p | 16'h0001);
    end
    return 32'(c & 16'((17'h1 << (l + 1)) - 1));
  endfunction : crc_of
  task automatic t_regs;
    rst;
    rc(A_CTL, 32'h40, "ctl reset");
    rc(A_POLY, 32'h0, "poly reset");
    wr(A_POLY, 16'hffff, 4'h3);
    rc(A_POLY, 32'hfffe, "poly bit0");
    wr(A_CTL, 16'hffff, 4'h3);
    rc(A_CTL, 32'h205f, "ctl access");
    rc(8'h14, 32'h0, "unmapped");
  endtask : t_regs
  task automatic t_crc16;
    time t0;
    logic [31:0] x;
    rst;
    wr(A_POLY, 16'h1020, 4'h3);
    wr(A_MSK, 16'h0001, 4'h1);
    wr(A_CTL, 16'h000f, 4'h3);
    wr(A_DATA, 16'h1234, 4'h3);
    wr(A_DATA, 16'habcd, 4'h3);
    rc(A_CTL, 32'h020f, "count two");
    wr(A_CTL, 16'h001f, 4'h3);
    t0 = $time;
    wait_empty;
    chk("drain", 34'h1, 34'(($time - t0) / 20 inside {[31:40]}));
    ci(1'b1);
    x = crc_of(32'h0, 16'h1234, 15, 16'h1020);
    rc(A_DATA, crc_of(x, 16'habcd, 15, 16'h1020), "two words");
  endtask : t_crc16
  task automatic t_lane;
    rst;
    wr(A_POLY, 16'h0012, 4'h3);
    wr(A_CTL, 16'h0008, 4'h1);
    wr(A_DATA, 16'h00a5, 4'h1);
    rc(A_CTL, 32'h48, "low lane only");
    wr(A_DATA, 16'hff01, 4'h2);
    rc(A_CTL, 32'h108, "top lane");
    wr(A_CTL, 16'h0018, 4'h1);
    wait_empty;
    rc(A_DATA, crc_of(32'h0, 16'h01a5, 8, 16'h0012), "masked element");
    ci(1'b0);
    rc(A_ST, 32'h1, "status");
    wr(A_MSK, 16'h0001, 4'h1);
    ci(1'b1);
    wr(A_ST, 16'h0001, 4'h1);
    ci(1'b0);
  endtask : t_lane
  task automatic t_wrap;
    int dp;
    for (int l = 7; l < 9; l++) begin
      dp = (l > 7) ? 8 : 16;
      rst;
      wr(A_MSK, 16'h0001, 4'h1);
      wr(A_CTL, 16'(l), 4'h1);
      for (int i = 0; i < dp; i++) wr(A_DATA, 16'(i), 4'h3);
      rc(A_CTL, 32'((dp << 8) | 32'h80 | l), "full");
      wr(A_DATA, 16'h0055, 4'h3);
      rc(A_CTL, 32'(32'h40 | l), "wrapped");
      ci(1'b0);
    end
  endtask : t_wrap
  task automatic t_sleep;
    logic [15:0] c;
    for (int m = 0; m < 3; m++) begin
      c = (m == 1) ? 16'h2007 : 16'h0007;
      rst;
      wr(A_CTL, c, 4'h3);
      wr(A_DATA, 16'h005a, 4'h1);
      sleep_req <= (m == 0);
      idle_req <= (m > 0);
      wr(A_CTL, c | 16'h0010, 4'h3);
      repeat (20) @(posedge clk_sys);
      rc(A_CTL, {16'h0, c} | ((m == 2) ? 32'h50 : 32'h110), "power save");
      sleep_req <= 1'b0;
      idle_req <= 1'b0;
      wait_empty;
      rc(A_DATA, crc_of(32'h0, 16'h005a, 7, 16'h0000), "resumed");
    end
  endtask : t_sleep
  // Prime four words, start, then top up while the count is below depth
  task automatic t_stream;
    logic [31:0] d;
    logic [31:0] x;
    logic [1:0] r;
    int n;
    rst;
    wr(A_POLY, 16'h8004, 4'h3);
    wr(A_CTL, 16'h000f, 4'h3);
    x = 32'h0;
    for (n = 0; n < 4; n++) begin
      wr(A_DATA, 16'h1111 * n[15:0], 4'h3);
      x = crc_of(x, 16'h1111 * n[15:0], 15, 16'h8004);
    end
    wr(A_CTL, 16'h001f, 4'h3);
    while (n < 12) begin
      rd(A_CTL, d, r);
      if (d[12:8] < 5'h08) begin
        wr(A_DATA, 16'h1111 * n[15:0], 4'h3);
        x = crc_of(x, 16'h1111 * n[15:0], 15, 16'h8004);
        n++;
      end
    end
    rc(A_ST, 32'h0, "no early irq");
    wait_empty;
    rc(A_DATA, x, "stream crc");
    rc(A_ST, 32'h1, "stream irq");
  endtask : t_stream
  initial begin
    t_regs;
    t_crc16;
    t_lane;
    t_wrap;
    t_sleep;
    t_stream;
    close_out;
  end
  initial begin
    #400000;
    bad_count++;
    close_out;
  end
endmodule : pcrc_top_tb
`default_nettype wire

// ### verilog/pcrc_core.sv
// Serial CRC shift register, one data bit per enabled clock.
// Assumes the front end presents MSb first and keeps poly stable while shifting.
`timescale 1ns/1ps
`default_nettype none
module pcrc_core (
  input wire logic clk_sys,
  input wire logic sys_rst,
  pcrc_shift_if.core sif
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic fb;
  logic [15:0] taps;
  // Feedback taken from the top bit of the programmed length
  assign fb = crc_q[sif.len] ^ sif.data_bit;
  // x^0 always, x^n per enable bit
  assign taps = (sif.poly & pcrc_pkg::POLY_IMPL_MASK) | 16'h0001;
  // x^16 for a 16-bit polynomial is the shifted-out bit itself
  assign crc_d = (crc_q << 1) ^ (fb ? taps : 16'h0000);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      crc_q <= 16'h0000;
    end else if (sif.bit_valid) begin
      crc_q <= crc_d;
    end
  end
  assign sif.crc = crc_q;
endmodule : pcrc_core
`default_nettype wire

// ### verilog/pcrc_top.sv
// Programmable CRC generator top: AXI4-Lite slave, word FIFO, shifter, interrupt.
// Assumes one clock, synchronous sleep/idle inputs from the power manager.
`timescale 1ns/1ps
`default_nettype none
module pcrc_top #(
  parameter int DEPTH_MAX = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sleep_req,
  input wire logic idle_req,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  pcrc_shift_if sif ();
  pcrc_core u_core (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sif(sif)
  );

  // Control state
  logic [3:0] len_q;
  logic go_q;
  logic stop_idle_q;
  logic [15:0] poly_q;
  logic irq_stat_q;
  logic irq_mask_q;
  logic irq_q;
  logic [4:0] count_q;
  logic [3:0] rd_ptr_q;
  logic [3:0] wr_ptr_q;
  logic [3:0] bit_q;
  logic [15:0] fifo_mem [DEPTH_MAX];
  logic [15:0] part_q;
  pcrc_pkg::pcrc_state_e state_q;

  // AXI write channel capture and read response registers
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == pcrc_pkg::ADDR_CONTROL) || (a == pcrc_pkg::ADDR_POLY) ||
      (a == pcrc_pkg::ADDR_DATA) || (a == pcrc_pkg::ADDR_IRQ_STATUS) ||
      (a == pcrc_pkg::ADDR_IRQ_MASK);
  endfunction : addr_known

  wire frozen = sleep_req | (idle_req & stop_idle_q);
  wire [4:0] depth = (len_q > pcrc_pkg::LEN_DEEP_MAX) ? pcrc_pkg::DEPTH_SHALLOW
    : pcrc_pkg::DEPTH_DEEP;
  wire full = (count_q == depth);
  wire empty = (count_q == 5'h00);

  // Write fires once address and data are both held and no response pends
  wire wr_fire = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_ctl = wr_fire & (aw_addr_q == pcrc_pkg::ADDR_CONTROL);
  wire wr_poly = wr_fire & (aw_addr_q == pcrc_pkg::ADDR_POLY);
  wire wr_data = wr_fire & (aw_addr_q == pcrc_pkg::ADDR_DATA);
  wire wr_stat = wr_fire & (aw_addr_q == pcrc_pkg::ADDR_IRQ_STATUS);
  wire wr_mask = wr_fire & (aw_addr_q == pcrc_pkg::ADDR_IRQ_MASK);

  // Byte that holds the element MSb: lane 1 for lengths above 8 bits
  wire top_lane_hi = (len_q > pcrc_pkg::LEN_DEEP_MAX);
  wire top_byte_wr = wr_data & (top_lane_hi ? w_strb_q[1] : w_strb_q[0]);
  wire [15:0] len_mask = 16'hffff >> (4'hf - len_q);
  wire [15:0] part_merged = {w_strb_q[1] ? w_data_q[15:8] : part_q[15:8],
    w_strb_q[0] ? w_data_q[7:0] : part_q[7:0]};
  wire [15:0] word_in = part_merged & len_mask;

  wire shifting = (state_q == pcrc_pkg::PCRC_SHIFT_ST) & ~frozen;
  wire last_bit = shifting & (bit_q == 4'h0);
  wire push = top_byte_wr & ~full;
  wire wrap = top_byte_wr & full;
  wire [15:0] head = fifo_mem[rd_ptr_q];

  // Count: wrap on full, else up for a push, down at a word's last bit
  logic [4:0] count_d;
  always_comb begin
    count_d = count_q;
    if (wrap) begin
      count_d = 5'h00;
    end else if (push & ~last_bit) begin
      count_d = count_q + 5'h01;
    end else if (last_bit & ~push) begin
      count_d = count_q - 5'h01;
    end
  end
  wire drain_evt = last_bit & ~push & (count_q == 5'h01);

  // Interrupt status; the setting event wins over a write-one clear
  wire stat_d = drain_evt | (irq_stat_q & ~(wr_stat & w_strb_q[0] & w_data_q[0]));

  assign sif.bit_valid = shifting;
  assign sif.data_bit = head[bit_q];
  assign sif.len = len_q;
  assign sif.poly = poly_q;

  wire [15:0] ctl_view = {2'b00, stop_idle_q, count_q, full, empty, 1'b0, go_q, len_q};
  wire [15:0] crc_view = sif.crc & len_mask;

  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      pcrc_pkg::ADDR_CONTROL: rd_mux = {16'h0000, ctl_view};
      pcrc_pkg::ADDR_POLY: rd_mux = {16'h0000, poly_q & pcrc_pkg::POLY_IMPL_MASK};
      pcrc_pkg::ADDR_DATA: rd_mux = {16'h0000, crc_view};
      pcrc_pkg::ADDR_IRQ_STATUS: rd_mux = {31'h00000000, irq_stat_q};
      pcrc_pkg::ADDR_IRQ_MASK: rd_mux = {31'h00000000, irq_mask_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // AXI write side
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= pcrc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= addr_known(aw_addr_q) ? pcrc_pkg::RESP_OKAY : pcrc_pkg::RESP_SLVERR;
      end else if (bvalid_q & s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // AXI read side, one cycle after the address is taken
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= pcrc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & ~rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= addr_known(s_axi_araddr) ? pcrc_pkg::RESP_OKAY : pcrc_pkg::RESP_SLVERR;
    end else if (rvalid_q & s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Control, polynomial and interrupt mask registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      len_q <= 4'h0;
      go_q <= 1'b0;
      stop_idle_q <= 1'b0;
      poly_q <= pcrc_pkg::POLY_RESET;
      irq_mask_q <= 1'b0;
    end else begin
      if (wr_ctl & w_strb_q[0]) begin
        len_q <= w_data_q[pcrc_pkg::CTL_LEN_LSB +: 4];
        go_q <= w_data_q[pcrc_pkg::CTL_GO];
      end
      if (wr_ctl & w_strb_q[1]) begin
        stop_idle_q <= w_data_q[pcrc_pkg::CTL_STOP_IDLE];
      end
      if (wr_poly) begin
        poly_q <= {w_strb_q[1] ? w_data_q[15:8] : poly_q[15:8],
          w_strb_q[0] ? w_data_q[7:0] : poly_q[7:0]} & pcrc_pkg::POLY_IMPL_MASK;
      end
      if (wr_mask & w_strb_q[0]) begin
        irq_mask_q <= w_data_q[0];
      end
    end
  end

  // Interrupt keeps propagating even while frozen
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= stat_d;
      irq_q <= stat_d & irq_mask_q;
    end
  end

  // FIFO storage and partial element assembly
  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= word_in;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      part_q <= 16'h0000;
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end else begin
      if (wr_data) begin
        part_q <= top_byte_wr ? 16'h0000 : part_merged;
      end
      if (wrap) begin
        wr_ptr_q <= 4'h0;
        rd_ptr_q <= 4'h0;
      end else begin
        if (push) begin
          wr_ptr_q <= wr_ptr_q + 4'h1;
        end
        if (last_bit) begin
          rd_ptr_q <= rd_ptr_q + 4'h1;
        end
      end
      count_q <= count_d;
    end
  end

  // Serial shifter, MSb of each element first
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= pcrc_pkg::PCRC_IDLE_ST;
      bit_q <= 4'h0;
    end else if (!frozen) begin
      case (state_q)
        pcrc_pkg::PCRC_IDLE_ST: begin
          if (go_q & ~empty & ~wrap) begin
            state_q <= pcrc_pkg::PCRC_SHIFT_ST;
            bit_q <= len_q;
          end
        end
        pcrc_pkg::PCRC_SHIFT_ST: begin
          if (wrap) begin
            state_q <= pcrc_pkg::PCRC_IDLE_ST;
          end else if (bit_q != 4'h0) begin
            bit_q <= bit_q - 4'h1;
          end else if (go_q & (count_d != 5'h00)) begin
            bit_q <= len_q;
          end else begin
            state_q <= pcrc_pkg::PCRC_IDLE_ST;
          end
        end
        default: state_q <= pcrc_pkg::PCRC_IDLE_ST;
      endcase
    end
  end

  assign s_axi_awready = ~aw_have_q;
  assign s_axi_wready = ~w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;
endmodule : pcrc_top
`default_nettype wire
